// ===== src/gtm_params.svh
// Constants of the general timer module: register offsets, field positions,
// reset values and timing counts. Assumes byte addresses on a 32-bit bus.
//
// Notes on behaviour
// - After reset all control is idle; both counters and interval loads read 0xffff.
// - After reset both prescale registers and prescale counters are zero.
// - Width 0 joins halves as 32-bit timer, width 1 as 32-bit clock.
// - Width 0x4 splits into two independent 16-bit halves with same controls.
// - Only clock mode uses the even pin; there is no odd pin.
// - Joined: 32-bit interval write fills first half low, second half high.
// - Joined: first count read returns second half high, first half low.
// - Joined timer takes one-shot/periodic from first half mode only.
// - Joined timer counts down, reloads the cycle after zero, one-shot stops.
// - Reaching zero sets sticky raw flag; mask bit also sets masked flag, interrupt.
// - With trigger enable, zero gives a trigger pulse of exactly one clock.
// - Interval write while running loads the counter on the next clock.
// - A set stall bit freezes that counter until cleared, except the second half bit in joined timer mode.
// - Clock mode counts up, loaded with one when first selected.
// - Even pin carries a 32.768 kHz clock, divided here to 1 Hz ticks.
// - Clock count equal to match rolls to zero and keeps counting.
// - Clock match sets raw flag; with mask also masked flag and interrupt.
// - Writing the clock clear bit clears raw and masked clock flags.
// - Stall override keeps the clock counting despite either stall bit.
// - Split halves count down 16 bits with optional 8-bit prescaler.
// - Split half reloads load and prescale after zero; one-shot clears enable.
// - Prescale value N stretches each count step to N plus one clocks.
`ifndef GTM_PARAMS_SVH
`define GTM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define GTM_OFS_CFG 8'h00
`define GTM_OFS_AMODE 8'h04
`define GTM_OFS_BMODE 8'h08
`define GTM_OFS_CTL 8'h0c
`define GTM_OFS_IMR 8'h18
`define GTM_OFS_RIS 8'h1c
`define GTM_OFS_MIS 8'h20
`define GTM_OFS_ICR 8'h24
`define GTM_OFS_AILR 8'h28
`define GTM_OFS_BILR 8'h2c
`define GTM_OFS_AMATCH 8'h30
`define GTM_OFS_APR 8'h38
`define GTM_OFS_BPR 8'h3c
`define GTM_OFS_AR 8'h48
`define GTM_OFS_BR 8'h4c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GTM_CTL_A_EN 0
`define GTM_CTL_A_STALL 1
`define GTM_CTL_RTC_OVR 4
`define GTM_CTL_A_OTE 5
`define GTM_CTL_B_EN 8
`define GTM_CTL_B_STALL 9
`define GTM_CTL_B_OTE 13
`define GTM_ST_A_TO 0
`define GTM_ST_RTC 3
`define GTM_ST_B_TO 8

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define GTM_RST_CNT 16'hffff
`define GTM_RST_PRE 8'h00
`define GTM_RTC_LOAD 32'h0000_0001
`define GTM_PIN_CLK_HZ 32768
`define GTM_RTC_TICK_HZ 1

`endif

// ===== src/gtm_pkg.sv
// Types shared by the general timer module files.
// Assumes the constants header is compiled alongside.
package gtm_pkg;

    // Width configuration codes
    typedef enum logic [2:0] {
        GTM_CFG_32 = 3'h0,
        GTM_CFG_RTC = 3'h1,
        GTM_CFG_16 = 3'h4
    } gtm_cfg_t;

    // Per-half mode field codes
    typedef enum logic [1:0] {
        GTM_MODE_NONE = 2'h0,
        GTM_MODE_ONESHOT = 2'h1,
        GTM_MODE_PERIODIC = 2'h2,
        GTM_MODE_OTHER = 2'h3
    } gtm_mode_t;

    // Per-half control set
    typedef struct packed {
        logic en;
        logic stall;
        logic ote;
    } gtm_half_ctl_t;

    // Sticky event flags
    typedef struct packed {
        logic a_to;
        logic rtc;
        logic b_to;
    } gtm_flags_t;

endpackage

// ===== src/gtm_sync.sv
// Two-flop synchroniser for pin levels.
// Assumes the input is asynchronous to clk; only stage two is to be read.
`timescale 1ns/1ps
module gtm_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    // Stage one feeds stage two only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // gtm_sync

// ===== src/gtm_timer.sv
// General timer module top: two 16-bit halves, joined 32-bit timer or clock.
// Assumes an Avalon-MM master on clk and a 32.768 kHz level on the even pin.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "gtm_params.svh"
module gtm_timer import gtm_pkg::*; #(
    parameter int RTC_DIV = `GTM_PIN_CLK_HZ / `GTM_RTC_TICK_HZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Capture/compare pin, even numbered
    input wire logic ccp_even,
    // Events out
    output logic irq,
    output logic trig_a,
    output logic trig_b
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    gtm_cfg_t cfg_r;
    gtm_mode_t mode_a_r;
    gtm_mode_t mode_b_r;
    gtm_half_ctl_t ctl_a_r;
    gtm_half_ctl_t ctl_b_r;
    logic rtc_ovr_r;
    gtm_flags_t imr_r;
    gtm_flags_t ris_r;
    gtm_flags_t ris_nxt;
    gtm_flags_t set_ev;
    gtm_flags_t clr_ev;
    logic [15:0] ilr_a_r;
    logic [15:0] ilr_b_r;
    logic [7:0] pr_a_r;
    logic [7:0] pr_b_r;
    logic [31:0] match_r;
    logic [15:0] cnt_a_r;
    logic [15:0] cnt_b_r;
    logic [7:0] pre_a_r;
    logic [7:0] pre_b_r;
    logic rtc_loaded_r;
    logic [31:0] div_r;
    logic pin_s;
    logic pin_d_r;
    logic [31:0] rdata;
    logic wr_take;
    logic [31:0] cnt32;

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // Waitrequest drops for one cycle after a request is seen; the access
    // lands on that edge. Costs one wait state but keeps outputs registered.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~(read | write);
        end
    end

    assign wr_take = write & ~waitrequest;

    // Read data captured one cycle before the accepting edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h0000_0000;
        end else if (read & waitrequest) begin
            readdata <= rdata;
        end
    end

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    logic is32;
    logic isrtc;
    logic is16;
    logic joined;
    logic valid_a;
    logic valid_b;
    logic run32;
    logic run_a;
    logic run_b;
    logic rtc_run;
    logic rtc_tick;

    assign is32 = (cfg_r == GTM_CFG_32);
    assign isrtc = (cfg_r == GTM_CFG_RTC);
    assign is16 = (cfg_r == GTM_CFG_16);
    assign joined = is32 | isrtc;
    assign cnt32 = {cnt_b_r, cnt_a_r};

    // Only one-shot and periodic count; other mode codes hold
    assign valid_a = (mode_a_r == GTM_MODE_ONESHOT) | (mode_a_r == GTM_MODE_PERIODIC);
    assign valid_b = (mode_b_r == GTM_MODE_ONESHOT) | (mode_b_r == GTM_MODE_PERIODIC);

    // Joined timer follows first half mode and stall only
    assign run32 = is32 & ctl_a_r.en & ~ctl_a_r.stall & valid_a;
    assign run_a = is16 & ctl_a_r.en & ~ctl_a_r.stall & valid_a;
    assign run_b = is16 & ctl_b_r.en & ~ctl_b_r.stall & valid_b;
    // Override lets the clock ignore both stall bits
    assign rtc_run = isrtc & ctl_a_r.en & rtc_loaded_r
        & (rtc_ovr_r | ~(ctl_a_r.stall | ctl_b_r.stall));

    // ------------------------------------------------------------------------
    // Clock-mode pin divider
    // ------------------------------------------------------------------------
    // Only the even pin is sampled; there is no odd pin input
    gtm_sync #(
        .W(1)
    ) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(ccp_even),
        .sync_out(pin_s)
    );

    // Rising-edge detect on the synchronised level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_d_r <= 1'b0;
        end else begin
            pin_d_r <= pin_s;
        end
    end

    // Divide pin edges down to a once-a-second tick
    assign rtc_tick = pin_s & ~pin_d_r & (div_r == 32'(RTC_DIV - 1));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= 32'h0000_0000;
        end else if (!(isrtc & ctl_a_r.en)) begin
            div_r <= 32'h0000_0000;
        end else if (pin_s & ~pin_d_r) begin
            div_r <= rtc_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------------
    // Counter events
    // ------------------------------------------------------------------------
    logic step_a;
    logic step_b;
    logic to32;
    logic rl32;
    logic to_a;
    logic rl_a;
    logic to_b;
    logic rl_b;
    logic rtc_hit;
    logic done_a;
    logic done_b;

    // Prescaler wrap gives one count step per N+1 clocks
    assign step_a = run_a & (pre_a_r == 8'h00);
    assign step_b = run_b & (pre_b_r == 8'h00);
    // Timeout when the count lands on zero; reload one step later
    assign to32 = run32 & (cnt32 == 32'h0000_0001);
    assign rl32 = run32 & (cnt32 == 32'h0000_0000);
    assign to_a = step_a & (cnt_a_r == 16'h0001);
    assign rl_a = step_a & (cnt_a_r == 16'h0000);
    assign to_b = step_b & (cnt_b_r == 16'h0001);
    assign rl_b = step_b & (cnt_b_r == 16'h0000);
    assign rtc_hit = rtc_run & rtc_tick & (cnt32 == match_r);
    // One-shot drops its own enable at reload
    assign done_a = (rl32 | rl_a) & (mode_a_r == GTM_MODE_ONESHOT);
    assign done_b = rl_b & (mode_b_r == GTM_MODE_ONESHOT);

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= GTM_CFG_32;
            mode_a_r <= GTM_MODE_NONE;
            mode_b_r <= GTM_MODE_NONE;
            imr_r <= '0;
            match_r <= 32'hffff_ffff;
            pr_a_r <= `GTM_RST_PRE;
            pr_b_r <= `GTM_RST_PRE;
        end else if (wr_take) begin
            case (address)
                `GTM_OFS_CFG: cfg_r <= gtm_cfg_t'(writedata[2:0]);
                `GTM_OFS_AMODE: mode_a_r <= gtm_mode_t'(writedata[1:0]);
                `GTM_OFS_BMODE: mode_b_r <= gtm_mode_t'(writedata[1:0]);
                `GTM_OFS_IMR: begin
                    imr_r.a_to <= writedata[`GTM_ST_A_TO];
                    imr_r.rtc <= writedata[`GTM_ST_RTC];
                    imr_r.b_to <= writedata[`GTM_ST_B_TO];
                end
                `GTM_OFS_AMATCH: match_r <= writedata;
                `GTM_OFS_APR: pr_a_r <= writedata[7:0];
                `GTM_OFS_BPR: pr_b_r <= writedata[7:0];
                default: ;
            endcase
        end
    end

    // Interval loads; joined write splits the word across both halves
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ilr_a_r <= `GTM_RST_CNT;
            ilr_b_r <= `GTM_RST_CNT;
        end else if (wr_take && address == `GTM_OFS_AILR) begin
            ilr_a_r <= writedata[15:0];
            if (joined) begin
                ilr_b_r <= writedata[31:16];
            end
        end else if (wr_take && address == `GTM_OFS_BILR && is16) begin
            ilr_b_r <= writedata[15:0];
        end
    end

    // Control: software writes, one-shot completion clears enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_a_r <= '0;
            ctl_b_r <= '0;
            rtc_ovr_r <= 1'b0;
        end else if (wr_take && address == `GTM_OFS_CTL) begin
            ctl_a_r.en <= writedata[`GTM_CTL_A_EN];
            ctl_a_r.stall <= writedata[`GTM_CTL_A_STALL];
            ctl_a_r.ote <= writedata[`GTM_CTL_A_OTE];
            ctl_b_r.en <= writedata[`GTM_CTL_B_EN];
            ctl_b_r.stall <= writedata[`GTM_CTL_B_STALL];
            ctl_b_r.ote <= writedata[`GTM_CTL_B_OTE];
            rtc_ovr_r <= writedata[`GTM_CTL_RTC_OVR];
        end else begin
            if (done_a) begin
                ctl_a_r.en <= 1'b0;
            end
            if (done_b) begin
                ctl_b_r.en <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------------
    // First entry to clock mode preloads one, later entries keep the count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rtc_loaded_r <= 1'b0;
        end else if (isrtc) begin
            rtc_loaded_r <= 1'b1;
        end
    end

    // Interval write wins over counting so the new value shows next clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_a_r <= `GTM_RST_CNT;
            cnt_b_r <= `GTM_RST_CNT;
            pre_a_r <= `GTM_RST_PRE;
            pre_b_r <= `GTM_RST_PRE;
        end else if (isrtc) begin
            if (!rtc_loaded_r) begin
                {cnt_b_r, cnt_a_r} <= `GTM_RTC_LOAD;
            end else if (rtc_hit) begin
                {cnt_b_r, cnt_a_r} <= 32'h0000_0000;
            end else if (rtc_run & rtc_tick) begin
                {cnt_b_r, cnt_a_r} <= cnt32 + 32'h0000_0001;
            end
        end else if (is32) begin
            if (wr_take && address == `GTM_OFS_AILR) begin
                {cnt_b_r, cnt_a_r} <= writedata;
            end else if (rl32) begin
                {cnt_b_r, cnt_a_r} <= {ilr_b_r, ilr_a_r};
            end else if (run32) begin
                {cnt_b_r, cnt_a_r} <= cnt32 - 32'h0000_0001;
            end
        end else if (is16) begin
            // First half
            if (wr_take && address == `GTM_OFS_AILR) begin
                cnt_a_r <= writedata[15:0];
                pre_a_r <= pr_a_r;
            end else if (rl_a) begin
                cnt_a_r <= ilr_a_r;
                pre_a_r <= pr_a_r;
            end else if (step_a) begin
                cnt_a_r <= cnt_a_r - 16'h0001;
                pre_a_r <= pr_a_r;
            end else if (run_a) begin
                pre_a_r <= pre_a_r - 8'h01;
            end
            // Second half
            if (wr_take && address == `GTM_OFS_BILR) begin
                cnt_b_r <= writedata[15:0];
                pre_b_r <= pr_b_r;
            end else if (rl_b) begin
                cnt_b_r <= ilr_b_r;
                pre_b_r <= pr_b_r;
            end else if (step_b) begin
                cnt_b_r <= cnt_b_r - 16'h0001;
                pre_b_r <= pr_b_r;
            end else if (run_b) begin
                pre_b_r <= pre_b_r - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Flags, interrupt and triggers
    // ------------------------------------------------------------------------
    // A set in the same cycle as its clear survives
    always_comb begin
        set_ev.a_to = to32 | to_a;
        set_ev.b_to = to_b;
        set_ev.rtc = rtc_hit;
        clr_ev = '0;
        if (wr_take && address == `GTM_OFS_ICR) begin
            clr_ev.a_to = writedata[`GTM_ST_A_TO];
            clr_ev.rtc = writedata[`GTM_ST_RTC];
            clr_ev.b_to = writedata[`GTM_ST_B_TO];
        end
        ris_nxt = (ris_r & ~clr_ev) | set_ev;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ris_r <= '0;
        end else begin
            ris_r <= ris_nxt;
        end
    end

    // Masked view drives the single interrupt line
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ris_nxt & imr_r);
        end
    end

    // One clock pulse each time a split half or the joined timer lands on zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trig_a <= 1'b0;
            trig_b <= 1'b0;
        end else begin
            trig_a <= ctl_a_r.ote & (to32 | to_a);
            trig_b <= ctl_b_r.ote & to_b;
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (address)
            `GTM_OFS_CFG: rdata[2:0] = cfg_r;
            `GTM_OFS_AMODE: rdata[1:0] = mode_a_r;
            `GTM_OFS_BMODE: rdata[1:0] = mode_b_r;
            `GTM_OFS_CTL: begin
                rdata[`GTM_CTL_A_EN] = ctl_a_r.en;
                rdata[`GTM_CTL_A_STALL] = ctl_a_r.stall;
                rdata[`GTM_CTL_A_OTE] = ctl_a_r.ote;
                rdata[`GTM_CTL_B_EN] = ctl_b_r.en;
                rdata[`GTM_CTL_B_STALL] = ctl_b_r.stall;
                rdata[`GTM_CTL_B_OTE] = ctl_b_r.ote;
                rdata[`GTM_CTL_RTC_OVR] = rtc_ovr_r;
            end
            `GTM_OFS_IMR: begin
                rdata[`GTM_ST_A_TO] = imr_r.a_to;
                rdata[`GTM_ST_RTC] = imr_r.rtc;
                rdata[`GTM_ST_B_TO] = imr_r.b_to;
            end
            `GTM_OFS_RIS: begin
                rdata[`GTM_ST_A_TO] = ris_r.a_to;
                rdata[`GTM_ST_RTC] = ris_r.rtc;
                rdata[`GTM_ST_B_TO] = ris_r.b_to;
            end
            `GTM_OFS_MIS: begin
                rdata[`GTM_ST_A_TO] = ris_r.a_to & imr_r.a_to;
                rdata[`GTM_ST_RTC] = ris_r.rtc & imr_r.rtc;
                rdata[`GTM_ST_B_TO] = ris_r.b_to & imr_r.b_to;
            end
            `GTM_OFS_AILR: rdata = joined ? {ilr_b_r, ilr_a_r} : {16'h0000, ilr_a_r};
            `GTM_OFS_BILR: rdata[15:0] = ilr_b_r;
            `GTM_OFS_AMATCH: rdata = match_r;
            `GTM_OFS_APR: rdata[7:0] = pr_a_r;
            `GTM_OFS_BPR: rdata[7:0] = pr_b_r;
            `GTM_OFS_AR: rdata = joined ? cnt32 : {16'h0000, cnt_a_r};
            `GTM_OFS_BR: rdata[15:0] = cnt_b_r;
            default: rdata = 32'h0000_0000;
        endcase
    end

endmodule // gtm_timer

// ===== sim/gtm_timer_checker.sv
// Port-level checks of the general timer module.
// Assumes a bind onto gtm_timer, one clock, resetn active low.
`timescale 1ns/1ps
module gtm_timer_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register bus
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Events
    input wire logic irq,
    input wire logic trig_a,
    input wire logic trig_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------------
    // Bus handshake and event outputs
    // ------------------------------------------------------------------
    wait_once_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for two cycles");
    wait_cause_a: assert property (!waitrequest |-> $past(read || write))
        else $error("accept without a request");
    wait_answer_a: assert property ($rose(read || write) |=> !waitrequest)
        else $error("request not answered after one wait state");
    trig_a_pulse_a: assert property (trig_a |=> !trig_a)
        else $error("first trigger longer than one cycle");
    trig_b_pulse_a: assert property (trig_b |=> !trig_b)
        else $error("second trigger longer than one cycle");
    reset_quiet_a: assert property ($rose(resetn) |-> waitrequest && !irq && !trig_a && !trig_b)
        else $error("outputs active right after reset");
    // Unmapped offsets must read as zero
    unmapped_zero_a: assert property (read && !waitrequest && address == 8'h10 |-> readdata == 32'h0)
        else $error("unmapped offset read not zero");
    // Masking everything drops the interrupt two edges later
    irq_mask_a: assert property (write && !waitrequest && address == 8'h18 && writedata == 32'h0
        |-> ##2 !irq)
        else $error("irq stays up with mask cleared");
endmodule // gtm_timer_checker
bind gtm_timer gtm_timer_checker i_gtm_timer_checker (.clk(clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .trig_a(trig_a), .trig_b(trig_b));

// ===== sim/gtm_timer_tb.sv
// Self-checking bench of the general timer module over its register bus.
// Assumes the checker is bound separately; clock divider shortened to 4.
`timescale 1ns/1ps
`include "gtm_params.svh"
module gtm_timer_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic ccp_even = 1'b0;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic trig_a;
    logic trig_b;
    logic [31:0] q;
    logic [31:0] q2;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int pin_div = 0;
    int trig_a_n = 0;
    int trig_b_n = 0;
    // ------------------------------------------------------------------
    // Clocks, device, bus tasks
    // ------------------------------------------------------------------
    always #12.5 clk = ~clk;
    // Pin clock near 32.768 kHz, half period 610 clocks; trigger pulses counted
    always @(posedge clk) begin
        pin_div <= (pin_div == 609) ? 0 : pin_div + 1;
        if (pin_div == 609)
            ccp_even <= ~ccp_even;
        trig_a_n <= trig_a_n + int'(trig_a);
        trig_b_n <= trig_b_n + int'(trig_b);
    end
    gtm_timer #(.RTC_DIV(4)) i_gtm_timer (.clk(clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .ccp_even(ccp_even), .irq(irq), .trig_a(trig_a),
        .trig_b(trig_b));
    task automatic summarize();
        $display("errors %0d, compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Bounded poll of one status bit; the cycle ceiling also guards it
    task automatic poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            xfer(1'b0, a, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 3000);
    endtask
    // Hang guard, well above the expected run of about 4300 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        rdc(`GTM_OFS_AR, 32'hffff_ffff);
        rdc(`GTM_OFS_BR, 32'h0000_ffff);
        rdc(`GTM_OFS_APR, 32'h0);
        rdc(`GTM_OFS_BPR, 32'h0);
        rdc(`GTM_OFS_CTL, 32'h0);
        rdc(8'h10, 32'h0);
        // Joined one-shot; second half mode set to periodic must not matter
        wr(`GTM_OFS_CFG, 32'h0);
        wr(`GTM_OFS_AMODE, 32'h1);
        wr(`GTM_OFS_BMODE, 32'h2);
        wr(`GTM_OFS_AILR, 32'h0001_0000);
        rdc(`GTM_OFS_AR, 32'h0001_0000);
        rdc(`GTM_OFS_AILR, 32'h0001_0000);
        rdc(`GTM_OFS_BILR, 32'h0000_0001);
        wr(`GTM_OFS_AILR, 32'h5);
        wr(`GTM_OFS_IMR, 32'h1);
        wr(`GTM_OFS_CTL, 32'h21);
        poll(`GTM_OFS_RIS, 0);
        chk(trig_a_n, 32'h1);
        rdc(`GTM_OFS_CTL, 32'h20);
        rdc(`GTM_OFS_MIS, 32'h1);
        chk(irq, 1'b1);
        rdc(`GTM_OFS_AR, 32'h5);
        wr(`GTM_OFS_ICR, 32'h1);
        rdc(`GTM_OFS_RIS, 32'h0);
        // Periodic keeps its enable; stall freezes the count
        wr(`GTM_OFS_AMODE, 32'h2);
        wr(`GTM_OFS_CTL, 32'h1);
        poll(`GTM_OFS_RIS, 0);
        rdc(`GTM_OFS_CTL, 32'h1);
        wr(`GTM_OFS_CTL, 32'h3);
        xfer(1'b0, `GTM_OFS_AR, 32'h0);
        q2 = q;
        rdc(`GTM_OFS_AR, q2);
        wr(`GTM_OFS_CTL, 32'h0);
        wr(`GTM_OFS_IMR, 32'h0);
        wr(`GTM_OFS_ICR, 32'h1);
        // Split halves: first one-shot, second periodic with prescale
        wr(`GTM_OFS_CFG, 32'h4);
        wr(`GTM_OFS_BPR, 32'h3);
        rdc(`GTM_OFS_BPR, 32'h3);
        wr(`GTM_OFS_AILR, 32'h3);
        wr(`GTM_OFS_BILR, 32'h4);
        wr(`GTM_OFS_AMODE, 32'h1);
        wr(`GTM_OFS_BMODE, 32'h2);
        wr(`GTM_OFS_CTL, 32'h2101);
        poll(`GTM_OFS_RIS, 8);
        chk(trig_b_n, 32'h1);
        rdc(`GTM_OFS_CTL, 32'h2100);
        chk(trig_a_n, 32'h1);
        rdc(`GTM_OFS_RIS, 32'h101);
        rdc(`GTM_OFS_AR, 32'h3);
        wr(`GTM_OFS_CTL, 32'h0);
        wr(`GTM_OFS_ICR, 32'h109);
        // Clock mode: stalled but overridden, match at the loaded one
        wr(`GTM_OFS_CFG, 32'h1);
        wr(`GTM_OFS_AMATCH, 32'h1);
        wr(`GTM_OFS_IMR, 32'h8);
        wr(`GTM_OFS_CTL, 32'h13);
        poll(`GTM_OFS_RIS, 3);
        rdc(`GTM_OFS_MIS, 32'h8);
        chk(irq, 1'b1);
        rdc(`GTM_OFS_AR, 32'h0);
        wr(`GTM_OFS_ICR, 32'h8);
        rdc(`GTM_OFS_RIS, 32'h0);
        rdc(`GTM_OFS_MIS, 32'h0);
        summarize();
    end
endmodule // gtm_timer_tb
